// ---- src/exd_dispatch.v ----
`timescale 1ns/100ps
`default_nettype none
`include "exd_map.vh"
// Exception recognition and dispatch with an AXI4-Lite register port
module exd_dispatch (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Asynchronous sources from pins
  input wire sys_reset_req_i,
  input wire sys_reset_corrupt_i,
  input wire mcheck_req_i,
  input wire mcheck_corrupt_i,
  input wire ext_irq_req_i,
  input wire decr_req_i,
  // Synchronous sources from the pipeline
  input wire dstore_fault_i,
  input wire instruction_storage_fault_i,
  input wire align_fault_i,
  input wire fp_imprecise_i,
  input wire older_pending_i,
  input wire [31:0] exc_pc_i,
  // Dispatch to the pipeline
  output reg take_o,
  output reg [31:0] vector_o,
  output reg [1:0] class_o,
  output reg checkstop_o,
  output reg irq_o,
  // AXI4-Lite slave
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // Synchronised pin levels
  wire [5:0] pins;
  wire s_reset;
  wire s_rcorrupt;
  wire s_mcheck;
  wire s_mcorrupt;
  wire s_ext;
  wire s_decr;

  // Architectural state
  reg [`EXD_MST_W-1:0] machine_state_reg; // Recoverable, user, base, enables
  reg [31:0] save_restore_pc; // Resume address
  reg [31:0] save_restore_state; // Copy of machine state
  reg [`EXD_NEVT-1:0] status; // Sticky event bits, write one to clear
  reg [`EXD_NEVT-1:0] mask; // Interrupt enables per event
  reg [`EXD_NSRC-1:0] pend; // Qualified requests this cycle
  reg [`EXD_NSRC-1:0] grant; // One-hot winner
  reg mc_stop; // Machine check seen while disabled

  // Bus bookkeeping
  reg [31:0] aw_addr; // Latched write address
  reg [31:0] w_data; // Latched write data
  reg [3:0] w_strb; // Latched strobes
  reg [`EXD_NEVT-1:0] next_status;
  wire wr_go;
  wire wr_hit;
  wire [3:0] wr_idx;
  wire [3:0] rd_idx;

  exd_sync #(
    .W(6)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i({decr_req_i, ext_irq_req_i, mcheck_corrupt_i, mcheck_req_i,
      sys_reset_corrupt_i, sys_reset_req_i}),
    .sync_o(pins)
  );
  // External events are sampled only after crossing into this clock
  assign {s_decr, s_ext, s_mcorrupt, s_mcheck, s_rcorrupt, s_reset} = pins; // see RULE1

  // Fixed-priority pick: lowest index wins
  function [`EXD_NSRC-1:0] pick;
    input [`EXD_NSRC-1:0] req;
    integer k;
    reg done;
    begin
      pick = {`EXD_NSRC{1'b0}};
      done = 1'b0;
      for (k = 0; k < `EXD_NSRC; k = k + 1)
      begin
        if (req[k] && !done)
        begin
          pick[k] = 1'b1;
          done = 1'b1;
        end
      end
    end
  endfunction

  // Word index of a byte address, or an out-of-range marker
  function [3:0] reg_index;
    input [31:0] addr;
    begin
      if (addr[31:6] == 26'h0 && addr[1:0] == 2'h0 && addr[5:2] <= `EXD_REG_LAST)
        reg_index = addr[5:2];
      else
        reg_index = 4'hf;
    end
  endfunction

  // Merge a written word into a register under the byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
      begin
        if (strb[b])
          merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // Qualify sources and arbitrate
  always @*
  begin
    pend = {`EXD_NSRC{1'b0}};
    // Unmaskable sources are never held back by the pipeline
    pend[`EXD_SRC_RESET] = s_reset; // see RULE1
    pend[`EXD_SRC_MCHECK] = s_mcheck && machine_state_reg[`EXD_MST_MCEN]; // see RULE7
    // Everything else waits for older instructions to finish
    if (!older_pending_i)
    begin
      pend[`EXD_SRC_DSTORE] = dstore_fault_i; // see RULE9
      pend[`EXD_SRC_ISTORE] = instruction_storage_fault_i; // see RULE10
      pend[`EXD_SRC_ALIGN] = align_fault_i; // see RULE12
      pend[`EXD_SRC_EXTIRQ] = s_ext && machine_state_reg[`EXD_MST_EXTEN]; // see RULE11
      pend[`EXD_SRC_DECR] = s_decr && machine_state_reg[`EXD_MST_EXTEN]; // see RULE1
    end
    // Lowest index wins: reset, then check, then the rest
    grant = pick(pend); // see RULE13 see RULE16
  end

  // Dispatch: vector, class and context save
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      take_o <= 1'b0;
      vector_o <= 32'h00000000;
      class_o <= `EXD_CLS_ASYNC_NMI;
      mc_stop <= 1'b0;
    end
    else
    begin
      take_o <= 1'b0;
      // Checkstop freezes dispatch until reset
      if (s_mcheck && !machine_state_reg[`EXD_MST_MCEN])
        mc_stop <= 1'b1; // see RULE7
      if (!mc_stop && (grant != {`EXD_NSRC{1'b0}}))
      begin
        take_o <= 1'b1; // see RULE14
        // Base from the prefix bit plus the fixed offset
        vector_o <= (machine_state_reg[`EXD_MST_VBASE] ? `EXD_BASE_HIGH : `EXD_BASE_LOW)
          | (grant[`EXD_SRC_RESET] ? `EXD_OFF_RESET : // see RULE4
             grant[`EXD_SRC_MCHECK] ? `EXD_OFF_MCHECK : // see RULE6
             grant[`EXD_SRC_DSTORE] ? `EXD_OFF_DSTORE : // see RULE9
             grant[`EXD_SRC_ISTORE] ? `EXD_OFF_ISTORE : // see RULE10
             grant[`EXD_SRC_ALIGN] ? `EXD_OFF_ALIGN : // see RULE12
             grant[`EXD_SRC_EXTIRQ] ? `EXD_OFF_EXTIRQ : // see RULE11
             `EXD_OFF_DECR); // see RULE3
        // Class follows the source kind
        if (grant[`EXD_SRC_RESET] || grant[`EXD_SRC_MCHECK])
          class_o <= `EXD_CLS_ASYNC_NMI; // see RULE1
        else if (grant[`EXD_SRC_EXTIRQ] || grant[`EXD_SRC_DECR])
          class_o <= `EXD_CLS_ASYNC_MASK; // see RULE1
        else if (fp_imprecise_i)
          class_o <= `EXD_CLS_SYNC_IMPR; // see RULE2
        else
          class_o <= `EXD_CLS_SYNC_PREC; // see RULE2
      end
    end
  end

  // Write channel handshakes; address and data may come in any order
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = reg_index(aw_addr);
  assign wr_hit = wr_idx != 4'hf;
  assign rd_idx = reg_index(s_axi_araddr);
  wire [31:0] mst_image = merge({27'h0, machine_state_reg}, w_data, w_strb); // Write image

  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EXD_RESP_OKAY;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      // Hold each channel once taken, until the response is accepted
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `EXD_RESP_OKAY : `EXD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Sticky status: a hardware set in the same cycle beats the clear
  always @*
  begin
    next_status = status;
    if (wr_go && wr_idx == `EXD_REG_STAT && w_strb[0])
      next_status = status & ~w_data[`EXD_NEVT-1:0];
    if (!mc_stop)
      next_status[`EXD_NSRC-1:0] = next_status[`EXD_NSRC-1:0] | grant;
    if (s_mcheck && !machine_state_reg[`EXD_MST_MCEN])
      next_status[`EXD_SRC_CHKSTOP] = 1'b1; // see RULE7
  end

  // Architectural registers; a hardware save overrides a software write
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      machine_state_reg <= `EXD_MST_RESET;
      save_restore_pc <= 32'h00000000;
      save_restore_state <= 32'h00000000;
      status <= {`EXD_NEVT{1'b0}};
      mask <= {`EXD_NEVT{1'b0}};
      checkstop_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      status <= next_status;
      checkstop_o <= mc_stop;
      irq_o <= |(next_status & mask);
      // Software writes
      if (wr_go)
      begin
        case (wr_idx)
          `EXD_REG_MST: machine_state_reg <= mst_image[`EXD_MST_W-1:0];
          `EXD_REG_SRPC: save_restore_pc <= merge(save_restore_pc, w_data, w_strb);
          `EXD_REG_SRST: save_restore_state <= merge(save_restore_state, w_data, w_strb);
          `EXD_REG_MASK: mask <= w_strb[0] ? w_data[`EXD_NEVT-1:0] : mask;
          default: ; // Status handled above; vector and unmapped are read-only
        endcase
      end
      // Context save; the old copy is simply overwritten
      if (!mc_stop && (grant != {`EXD_NSRC{1'b0}}))
      begin
        save_restore_pc <= exc_pc_i; // see RULE14 see RULE15
        save_restore_state <= {27'h0, machine_state_reg[`EXD_MST_W-1:1],
          machine_state_reg[`EXD_MST_RECOV]
          & ~(grant[`EXD_SRC_RESET] & s_rcorrupt) // see RULE5
          & ~(grant[`EXD_SRC_MCHECK] & s_mcorrupt)}; // see RULE8
        // Handler runs in supervisor mode with maskable sources off
        machine_state_reg[`EXD_MST_USER] <= 1'b0; // see RULE14
        machine_state_reg[`EXD_MST_EXTEN] <= 1'b0;
        if (grant[`EXD_SRC_RESET] || grant[`EXD_SRC_MCHECK])
          machine_state_reg[`EXD_MST_RECOV] <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EXD_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (rd_idx == 4'hf) ? `EXD_RESP_SLVERR : `EXD_RESP_OKAY;
        case (rd_idx)
          `EXD_REG_MST: s_axi_rdata <= {27'h0, machine_state_reg};
          `EXD_REG_SRPC: s_axi_rdata <= save_restore_pc;
          `EXD_REG_SRST: s_axi_rdata <= save_restore_state;
          `EXD_REG_STAT: s_axi_rdata <= {24'h0, status};
          `EXD_REG_MASK: s_axi_rdata <= {24'h0, mask};
          `EXD_REG_VEC: s_axi_rdata <= vector_o;
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // exd_dispatch
`default_nettype wire

// ---- src/exd_map.vh ----
// Summary of operation
// RULE1: External events are asynchronous; reset, check unmaskable.
// RULE2: Instruction exceptions synchronous; float-imprecise ones imprecise.
// RULE3: Vector equals prefix-selected base plus offset.
// RULE4: System reset vectors to offset 00100.
// RULE5: Corrupting reset clears saved recoverable flag.
// RULE6: Machine check input vectors to offset 00200.
// RULE7: Check with enable clear enters checkstop.
// RULE8: Corrupting machine check clears saved recoverable flag.
// RULE9: Failed data access vectors to offset 00300.
// RULE10: Failed instruction fetch vectors to offset 00400.
// RULE11: External interrupt taken only when enabled.
// RULE12: Misaligned access may vector to 00600.
// RULE13: Exceptions wait for earlier instructions completing; the code takes reset and machine check without waiting.
// RULE14: Taking saves state, enters supervisor, redirects fetch.
// RULE15: Handler copies save registers before next exception.
// RULE16: Priority: reset, then check, then rest.
`ifndef EXD_MAP_VH
`define EXD_MAP_VH

// Vector bases picked by the prefix bit
`define EXD_BASE_LOW 32'h00000000
`define EXD_BASE_HIGH 32'hfff00000

// Per-exception vector offsets
`define EXD_OFF_RESET 32'h00000100
`define EXD_OFF_MCHECK 32'h00000200
`define EXD_OFF_DSTORE 32'h00000300
`define EXD_OFF_ISTORE 32'h00000400
`define EXD_OFF_EXTIRQ 32'h00000500
`define EXD_OFF_ALIGN 32'h00000600
`define EXD_OFF_DECR 32'h00000900

// Source indices, also status/mask bit positions
`define EXD_SRC_RESET 0
`define EXD_SRC_MCHECK 1
`define EXD_SRC_DSTORE 2
`define EXD_SRC_ISTORE 3
`define EXD_SRC_ALIGN 4
`define EXD_SRC_EXTIRQ 5
`define EXD_SRC_DECR 6
`define EXD_SRC_CHKSTOP 7
`define EXD_NSRC 7
`define EXD_NEVT 8

// Machine state register bit positions
`define EXD_MST_RECOV 0
`define EXD_MST_USER 1
`define EXD_MST_VBASE 2
`define EXD_MST_MCEN 3
`define EXD_MST_EXTEN 4
`define EXD_MST_W 5
`define EXD_MST_RESET 5'h18

// Exception class codes
`define EXD_CLS_ASYNC_NMI 2'h0
`define EXD_CLS_ASYNC_MASK 2'h1
`define EXD_CLS_SYNC_PREC 2'h2
`define EXD_CLS_SYNC_IMPR 2'h3

// Register word indices, byte address bits 5:2
`define EXD_REG_MST 4'h0
`define EXD_REG_SRPC 4'h1
`define EXD_REG_SRST 4'h2
`define EXD_REG_STAT 4'h3
`define EXD_REG_MASK 4'h4
`define EXD_REG_VEC 4'h5
`define EXD_REG_LAST 4'h5

// AXI responses
`define EXD_RESP_OKAY 2'h0
`define EXD_RESP_SLVERR 2'h2

`endif

// ---- src/exd_sync.v ----
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for a bundle of independent levels
module exd_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Levels
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

  reg [W-1:0] meta; // First stage, read only by the second

  // Each bit crosses on its own; bits are not coherent with each other
  always @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // exd_sync
`default_nettype wire

// ---- tb/exd_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// Port-level timing checks on exception dispatch
module exd_asserts (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Pins
  input wire sys_reset_req_i,
  input wire mcheck_req_i,
  input wire ext_irq_req_i,
  input wire decr_req_i,
  // Pipeline
  input wire dstore_fault_i,
  input wire instruction_storage_fault_i,
  input wire align_fault_i,
  input wire fp_imprecise_i,
  input wire older_pending_i,
  // Dispatch
  input wire take_o,
  input wire [31:0] vector_o,
  input wire [1:0] class_o,
  input wire checkstop_o
);
  // Pins low three edges, so nothing is left inside the synchroniser
  reg [1:0] calm_cnt;
  wire pins;
  wire calm;
  wire anyf;
  assign pins = sys_reset_req_i | mcheck_req_i | ext_irq_req_i | decr_req_i;
  assign calm = (calm_cnt == 2'h3) && !pins && !checkstop_o;
  assign anyf = dstore_fault_i | instruction_storage_fault_i | align_fault_i;
  // Counts quiet edges
  always @(posedge mclk_i)
  begin
    if (rst_i || pins)
      calm_cnt <= 2'h0;
    else if (calm_cnt != 2'h3)
      calm_cnt <= calm_cnt + 2'h1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  AST_DSTORE_VEC:
    assert property (calm && dstore_fault_i && !older_pending_i
      |=> take_o && vector_o[19:0] == 20'h00300) else $error("dstore vector");
  AST_ISTORE_VEC:
    assert property (calm && !dstore_fault_i && instruction_storage_fault_i && !older_pending_i
      |=> take_o && vector_o[19:0] == 20'h00400) else $error("istore vector");
  AST_ALIGN_VEC:
    assert property (calm && align_fault_i && !dstore_fault_i && !instruction_storage_fault_i
      && !older_pending_i |=> take_o && vector_o[19:0] == 20'h00600) else $error("align vector");
  AST_SYNC_CLASS:
    assert property (calm && anyf && !older_pending_i
      |=> class_o == {1'b1, $past(fp_imprecise_i)}) else $error("sync class");
  AST_OLDER_BLOCKS:
    assert property (calm && older_pending_i |=> !take_o) else $error("take before older");
  AST_CHECKSTOP_HOLD:
    assert property (checkstop_o |=> checkstop_o && !take_o) else $error("checkstop left");
  AST_CHECKSTOP_CAUSE:
    assert property ($rose(checkstop_o) |-> $past(mcheck_req_i, 3) || $past(mcheck_req_i, 4)
      || $past(mcheck_req_i, 5)) else $error("checkstop cause");
  AST_RESET_VEC:
    assert property (!checkstop_o && $rose(sys_reset_req_i) |-> ##[2:5]
      (take_o && vector_o[19:0] == 20'h00100 && class_o == 2'h0)) else $error("reset vector");
  AST_MCHECK_VEC:
    assert property (!checkstop_o && !sys_reset_req_i && $rose(mcheck_req_i) |-> ##[2:5]
      (checkstop_o || (take_o && vector_o[19:0] == 20'h00200))) else $error("check vector");
  // Main scenarios reached
  CV_IMPRECISE: cover property (take_o && class_o == 2'h3);
  CV_CHECKSTOP: cover property ($rose(checkstop_o));
  CV_EXTIRQ: cover property (take_o && vector_o[19:0] == 20'h00500);
endmodule // exd_asserts
bind exd_dispatch exd_asserts u_exd_asserts (.mclk_i, .rst_i, .sys_reset_req_i, .mcheck_req_i,
  .ext_irq_req_i, .decr_req_i, .dstore_fault_i, .instruction_storage_fault_i, .align_fault_i,
  .fp_imprecise_i, .older_pending_i, .take_o, .vector_o, .class_o, .checkstop_o);
`default_nettype wire

// ---- tb/exd_pin_src.sv ----
`timescale 1ns/100ps
`default_nettype none
// Far-side pin sources; one-cycle pulses so each request is taken once
module exd_pin_src (
  // Clock
  input wire logic mclk_i,
  // Request pins, idle low
  output logic sys_reset_req_o,
  output logic sys_reset_corrupt_o,
  output logic mcheck_req_o,
  output logic mcheck_corrupt_o,
  output logic ext_irq_req_o,
  output logic decr_req_o
);
  initial {sys_reset_req_o, sys_reset_corrupt_o, mcheck_req_o, mcheck_corrupt_o} = 4'h0;
  initial {ext_irq_req_o, decr_req_o} = 2'h0;
  // Pulse selected pins; corrupt flag travels with its request
  task automatic raise(input logic [3:0] sel, input logic bad);
    @(posedge mclk_i);
    {decr_req_o, ext_irq_req_o, mcheck_req_o, sys_reset_req_o} <= sel;
    sys_reset_corrupt_o <= bad & sel[0];
    mcheck_corrupt_o <= bad & sel[1];
    @(posedge mclk_i);
    {decr_req_o, ext_irq_req_o, mcheck_req_o, sys_reset_req_o} <= 4'h0;
    {sys_reset_corrupt_o, mcheck_corrupt_o} <= 2'h0;
  endtask
endmodule // exd_pin_src
`default_nettype wire

// ---- tb/tb_processor_exception_dispatch.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_processor_exception_dispatch;
  logic mclk_i, rst_i, ds, ist, al, fp, old, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] pc, awaddr, wdata, araddr;
  wire awready, wready, bvalid, arready, rvalid, take, cstop, irq;
  wire p_rst, p_rstc, p_mc, p_mcc, p_ext, p_dec;
  wire [1:0] bresp, rresp, cls;
  wire [31:0] rdata, vec;
  int mismatches, tests_run, i, j;
  logic [31:0] offs [3];
  exd_pin_src u_exd_pin_src (.mclk_i, .sys_reset_req_o(p_rst), .sys_reset_corrupt_o(p_rstc),
    .mcheck_req_o(p_mc), .mcheck_corrupt_o(p_mcc), .ext_irq_req_o(p_ext), .decr_req_o(p_dec));
  exd_dispatch u_exd_dispatch (.mclk_i, .rst_i, .sys_reset_req_i(p_rst),
    .sys_reset_corrupt_i(p_rstc), .mcheck_req_i(p_mc), .mcheck_corrupt_i(p_mcc),
    .ext_irq_req_i(p_ext), .decr_req_i(p_dec), .dstore_fault_i(ds),
    .instruction_storage_fault_i(ist), .align_fault_i(al), .fp_imprecise_i(fp),
    .older_pending_i(old), .exc_pc_i(pc), .take_o(take), .vector_o(vec), .class_o(cls),
    .checkstop_o(cstop), .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // 50 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic tally_and_finish;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // AXI write: address and data offered together, each dropped on its own handshake
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge mclk_i);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    bready <= 1'b0;
    chk(bvalid, 1);
    chk(bresp, er);
    @(posedge mclk_i);
  endtask
  // AXI read, compared under a bit mask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge mclk_i);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    rready <= 1'b0;
    chk(rvalid, 1);
    chk(rdata & m, e);
    chk(rresp, er);
    @(posedge mclk_i);
  endtask
  // Waits a bounded time for the take pulse, then checks vector and class
  task automatic await(input logic [31:0] ev, input logic [1:0] ec);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (take !== 1'b1 && n < 10);
    chk(take, 1);
    chk(vec, ev);
    chk(cls, ec);
  endtask
  task automatic no_take(input int k);
    repeat (k)
    begin
      @(posedge mclk_i);
      chk(take, 0);
    end
  endtask
  // One-cycle pipeline fault
  task automatic sync_go(input logic [2:0] f, input logic f_fp, input logic [31:0] ev,
                         input logic [1:0] ec);
    {al, ist, ds} <= f;
    fp <= f_fp;
    @(posedge mclk_i);
    {al, ist, ds, fp} <= 4'h0;
    await(ev, ec);
  endtask
  task automatic pin(input logic [3:0] s, input logic b, input logic [31:0] ev,
                     input logic [1:0] ec);
    fork
      u_exd_pin_src.raise(s, b);
      await(ev, ec);
    join
  endtask
  // Hang guard, far beyond the few hundred cycles of the sequence
  initial
  begin
    #(20 * 8000);
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    {rst_i, ds, ist, al, fp, old, awvalid, wvalid, bready, arvalid, rready} = 11'h400;
    {pc, awaddr, wdata, araddr} = 128'h0;
    mismatches = 0;
    tests_run = 0;
    offs = '{32'h300, 32'h400, 32'h600};
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(32'h0, 32'h18, 32'hffffffff, 2'h0);
    rd(32'h18, 32'h0, 32'h0, 2'h2);
    wr(32'h40, 32'h1, 2'h2);
    // Each synchronous source, imprecise on the last
    for (i = 0; i < 3; i++)
    begin
      pc <= 32'h1000 + i;
      sync_go(3'h1 << i, i == 2, offs[i], (i == 2) ? 2'h3 : 2'h2);
      rd(32'h4, 32'h1000 + i, 32'hffffffff, 2'h0);
      rd(32'hc, 32'h4 << i, 32'hff, 2'h0);
      wr(32'hc, 32'h4 << i, 2'h0);
      rd(32'hc, 32'h0, 32'hff, 2'h0);
    end
    sync_go(3'h7, 1'b0, 32'h300, 2'h2);
    sync_go(3'h6, 1'b0, 32'h400, 2'h2);
    // Fault held back while older work is unfinished
    {ds, old} <= 2'h3;
    no_take(3);
    old <= 1'b0;
    @(posedge mclk_i);
    ds <= 1'b0;
    await(32'h300, 2'h2);
    wr(32'h0, 32'h1e, 2'h0);
    sync_go(3'h1, 1'b0, 32'hfff00300, 2'h2);
    rd(32'h0, 32'h0c, 32'h1f, 2'h0);
    rd(32'h8, 32'h1e, 32'h1f, 2'h0);
    // Interrupt line unmasked, then masked; stale status cleared so only the take can raise it
    wr(32'hc, 32'hff, 2'h0);
    for (i = 0; i < 2; i++)
    begin
      wr(32'h10, i ? 32'h0 : 32'h4, 2'h0);
      sync_go(3'h1, 1'b0, 32'hfff00300, 2'h2);
      @(posedge mclk_i);
      chk(irq, !i);
      wr(32'hc, 32'h4, 2'h0);
      chk(irq, 0);
    end
    // Maskable pins taken when enabled, ignored when not
    for (i = 0; i < 2; i++)
    begin
      wr(32'h0, 32'h18, 2'h0);
      pin(4'h4 << i, 1'b0, i ? 32'h900 : 32'h500, 2'h1);
      wr(32'h0, 32'h08, 2'h0);
      fork
        u_exd_pin_src.raise(4'h4 << i, 1'b0);
        no_take(8);
      join
    end
    // Reset and check, clean and corrupting
    for (i = 0; i < 2; i++)
      for (j = 0; j < 2; j++)
      begin
        wr(32'h0, 32'h19, 2'h0);
        pin(4'h1 << i, j, i ? 32'h200 : 32'h100, 2'h0);
        rd(32'h8, !j, 32'h1, 2'h0);
      end
    wr(32'h0, 32'h19, 2'h0);
    pin(4'h3, 1'b0, 32'h100, 2'h0);
    // Disabled check stops the machine until reset
    wr(32'h0, 32'h10, 2'h0);
    fork
      u_exd_pin_src.raise(4'h2, 1'b0);
      no_take(8);
    join
    chk(cstop, 1);
    ds <= 1'b1;
    @(posedge mclk_i);
    ds <= 1'b0;
    no_take(3);
    rd(32'hc, 32'h80, 32'h80, 2'h0);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk(cstop, 0);
    tally_and_finish;
  end
endmodule // tb_processor_exception_dispatch
`default_nettype wire
